// *** uvp_pkg.sv ***
package uvp_pkg;
  // ----------------------------------------
  // Array geometry
  // ----------------------------------------
  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;
  localparam int WORDS = 2048;
  localparam logic [7:0] ERASED_WORD = 8'hff;

  // ----------------------------------------
  // Timing figures
  // ----------------------------------------
  localparam int CLK_MHZ = 50;
  localparam int CLK_NS = 20;
  localparam int PULSE_NOM_MS = 50;
  localparam int PULSE_MIN_MS = 45;
  localparam int PULSE_MAX_MS = 55;
  // Milliseconds times MHz first, then times 1000; the product stays inside int range
  localparam int PULSE_CYC = PULSE_NOM_MS * CLK_MHZ * 1000;
  localparam int SETUP_US = 2;
  localparam int SETUP_CYC = SETUP_US * CLK_MHZ;
  localparam int GATE_NS = 150;
  localparam int GATE_CYC = (GATE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SYNC_CYC = 2;

  // ----------------------------------------
  // Controller states
  // ----------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_RD_SETUP,
    ST_RD_WAIT,
    ST_PG_SUPPLY,
    ST_PG_SETUP,
    ST_PG_PULSE,
    ST_PG_HOLD,
    ST_VF_WAIT,
    ST_VF_HOLD
  } uvp_state_t;
endpackage

// *** uvp_host.sv ***
`timescale 1ns/1ps
// Overview of operation
// - Program mode needs high supply and gate high before strobe.
// - Programmer drives address and data pattern during programming.
// - One high strobe pulse, nominally 50 ms, 45 to 55 ms.
// - Never hold strobe statically high; one pulse per address.
// - Addresses may be programmed in any order.
// - Parallel devices share all inputs except their strobe.
// - Verify at high supply with enable and gate low.
// - Supply stays normal except during program and verify.
// - Never switch supply while gate and strobe both high.
// - Enable selects the device; gate follows the read strobe.
module uvp_host #(
  parameter int PULSE_CYCLES = uvp_pkg::PULSE_CYC,
  parameter int SETUP_CYCLES = uvp_pkg::SETUP_CYC
) (
  input wire logic clk,                  // 50 MHz clock
  input wire logic reset_n,              // Async reset, active low
  input wire logic readReq,              // Request one read
  input wire logic progReq,              // Request one program+verify
  input wire logic [10:0] reqAddr,       // Target address
  input wire logic [7:0] reqData,        // Pattern to program
  output logic reqReady,                 // Idle, request accepted
  output logic [7:0] rspData,            // Word read or verified
  output logic rspValid,                 // One-cycle answer pulse
  output logic progFail,                 // Verify mismatch with rspValid
  output logic [10:0] memAddr,           // Device address pins
  input wire logic [7:0] memDataIn,      // Device data pins, in
  output logic [7:0] memDataOut,         // Device data pins, out
  output logic memDataOe,                // High while host drives data
  output logic chipEnableProgramStrobe,  // Enable low / program pulse
  output logic outputGateLow,            // Output gate, active low
  output logic programSupplyHigh         // 1 = +25 V, 0 = logic supply
);
  // Counter wide enough for the longest legal pulse at this clock
  localparam int CW = 22;

  // ----------------------------------------
  // Parameter checks
  // ----------------------------------------
  // Refused at elaboration; a longer pulse could damage the cell
  if (PULSE_CYCLES < 2 || PULSE_CYCLES >= (1 << CW))
  begin : pulse_range_g
    $error("pulse length out of range");
  end
  if (PULSE_CYCLES > uvp_pkg::PULSE_MAX_MS * uvp_pkg::CLK_MHZ * 1000)
  begin : pulse_max_g
    $error("pulse longer than the programming limit");
  end
  if (SETUP_CYCLES < 1 || SETUP_CYCLES >= (1 << CW))
  begin : setup_range_g
    $error("setup length out of range");
  end

  // All state in one record: one comb copy, one register
  typedef struct packed {
    uvp_pkg::uvp_state_t st;
    logic [CW-1:0] cnt;
    logic [10:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic valid;
    logic fail;
    // Pin registers
    logic ce;
    logic oe;
    logic vpp;
    logic drive;
    // Two-flop synchroniser on the data pins
    logic [7:0] s1;
    logic [7:0] s2;
  } uvp_regs_t;

  // Registered state and its next value
  uvp_regs_t r;
  uvp_regs_t next_r;

  // Compare read-back against pattern
  function automatic logic mismatch(input logic [7:0] a, input logic [7:0] b);
    mismatch = (a != b);
  endfunction

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb
  begin
    next_r = r;
    next_r.valid = 1'b0;
    next_r.s1 = memDataIn;               // Pins are asynchronous
    next_r.s2 = r.s1;
    case (r.st)
      uvp_pkg::ST_IDLE:
      begin
        // Standby: enable high, gate high, supply normal
        next_r.ce = 1'b1;
        next_r.oe = 1'b1;
        next_r.vpp = 1'b0;
        next_r.drive = 1'b0;
        next_r.cnt = '0;
        if (progReq)
        begin
          // Any address order is accepted
          next_r.addr = reqAddr;
          next_r.wdata = reqData;
          next_r.fail = 1'b0;
          next_r.ce = 1'b0;              // Strobe low before supply moves
          next_r.st = uvp_pkg::ST_PG_SUPPLY;
        end
        else if (readReq)
        begin
          next_r.addr = reqAddr;
          next_r.ce = 1'b0;              // Enable selects device
          next_r.st = uvp_pkg::ST_RD_SETUP;
        end
      end
      uvp_pkg::ST_RD_SETUP:
      begin
        // Gate falls after address and enable settle
        next_r.oe = 1'b0;
        next_r.st = uvp_pkg::ST_RD_WAIT;
      end
      uvp_pkg::ST_RD_WAIT:
      begin
        // Access plus synchroniser delay covers gate-to-data
        next_r.cnt = r.cnt + 1'b1;
        if (r.cnt == CW'(uvp_pkg::GATE_CYC + uvp_pkg::SYNC_CYC))
        begin
          next_r.rdata = r.s2;
          next_r.valid = 1'b1;
          next_r.ce = 1'b1;
          next_r.oe = 1'b1;
          next_r.st = uvp_pkg::ST_IDLE;
        end
      end
      uvp_pkg::ST_PG_SUPPLY:
      begin
        // Gate high first, strobe low, then raise supply
        next_r.oe = 1'b1;
        next_r.ce = 1'b0;
        next_r.vpp = 1'b1;
        next_r.drive = 1'b1;             // Host drives the data pins
        next_r.cnt = '0;
        next_r.st = uvp_pkg::ST_PG_SETUP;
      end
      uvp_pkg::ST_PG_SETUP:
      begin
        // Address and data stable before the pulse
        next_r.cnt = r.cnt + 1'b1;
        if (r.cnt == CW'(SETUP_CYCLES - 1))
        begin
          next_r.cnt = '0;
          next_r.ce = 1'b1;
          next_r.st = uvp_pkg::ST_PG_PULSE;
        end
      end
      uvp_pkg::ST_PG_PULSE:
      begin
        // Exactly one bounded pulse, never static high
        next_r.cnt = r.cnt + 1'b1;
        if (r.cnt == CW'(PULSE_CYCLES - 1))
        begin
          next_r.cnt = '0;
          next_r.ce = 1'b0;
          next_r.st = uvp_pkg::ST_PG_HOLD;
        end
      end
      uvp_pkg::ST_PG_HOLD:
      begin
        // Hold data past the falling strobe, then release pins
        next_r.cnt = r.cnt + 1'b1;
        if (r.cnt == CW'(SETUP_CYCLES - 1))
        begin
          next_r.cnt = '0;
          next_r.drive = 1'b0;
          next_r.oe = 1'b0;              // Verify at high supply
          next_r.st = uvp_pkg::ST_VF_WAIT;
        end
      end
      uvp_pkg::ST_VF_WAIT:
      begin
        // Read back at high supply, same wait as a normal read
        next_r.cnt = r.cnt + 1'b1;
        if (r.cnt == CW'(uvp_pkg::GATE_CYC + uvp_pkg::SYNC_CYC))
        begin
          next_r.cnt = '0;
          next_r.rdata = r.s2;
          next_r.fail = mismatch(r.s2, r.wdata);
          next_r.oe = 1'b1;
          next_r.vpp = 1'b0;             // Supply drops, strobe low
          next_r.st = uvp_pkg::ST_VF_HOLD;
        end
      end
      uvp_pkg::ST_VF_HOLD:
      begin
        // Supply is normal again before the strobe rises into standby,
        // so a rising strobe can never act as a second program pulse
        next_r.cnt = r.cnt + 1'b1;
        if (r.cnt == CW'(SETUP_CYCLES - 1))
        begin
          next_r.ce = 1'b1;              // Standby at normal supply
          next_r.valid = 1'b1;
          next_r.st = uvp_pkg::ST_IDLE;
        end
      end
      default:
        next_r.st = uvp_pkg::ST_IDLE;
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      r <= '0;
      r.st <= uvp_pkg::ST_IDLE;
      r.ce <= 1'b1;
      r.oe <= 1'b1;
    end
    else
      r <= next_r;
  end

  // ----------------------------------------
  // Pin and answer outputs
  // ----------------------------------------
  // Outputs; strobe per device is this port alone
  assign reqReady = (r.st == uvp_pkg::ST_IDLE);
  assign rspData = r.rdata;
  assign rspValid = r.valid;
  assign progFail = r.fail;
  assign memAddr = r.addr;
  assign memDataOut = r.wdata;
  assign memDataOe = r.drive;
  assign chipEnableProgramStrobe = r.ce;
  assign outputGateLow = r.oe;
  assign programSupplyHigh = r.vpp;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Programming sequence, idle supply and read-mode pins
  pulse_length_a: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(r.ce) && r.vpp |-> (r.ce && r.vpp) [*2])
    else $error("strobe pulse too short");
  pulse_bound_a: assert property (@(posedge clk) disable iff (!reset_n)
    r.ce && r.vpp |-> r.st == uvp_pkg::ST_PG_PULSE
      && r.cnt < CW'(PULSE_CYCLES))
    else $error("strobe high outside its pulse");
  prog_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
    r.vpp && r.ce |-> r.oe)
    else $error("strobe with gate low at high supply");
  supply_switch_a: assert property (@(posedge clk)
    disable iff (!reset_n)
    $changed(r.vpp) |-> !($past(r.ce) && $past(r.oe)))
    else $error("supply switched with gate and strobe high");
  supply_idle_a: assert property (@(posedge clk) disable iff (!reset_n)
    r.st == uvp_pkg::ST_IDLE |-> !r.vpp)
    else $error("high supply while idle");
  no_contend_a: assert property (@(posedge clk) disable iff (!reset_n)
    r.drive |-> r.oe)
    else $error("host drives data with gate low");
  read_mode_a: assert property (@(posedge clk) disable iff (!reset_n)
    r.st == uvp_pkg::ST_RD_WAIT |-> !r.ce && !r.oe && !r.vpp)
    else $error("read pins wrong");
  verify_mode_a: assert property (@(posedge clk) disable iff (!reset_n)
    r.st == uvp_pkg::ST_VF_WAIT |-> !r.ce && !r.oe && r.vpp && !r.drive)
    else $error("verify pins wrong");
  supply_entry_a: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(r.vpp) |-> r.oe && !r.ce)
    else $error("supply raised with strobe high or gate low");
  addr_stable_a: assert property (@(posedge clk) disable iff (!reset_n)
    r.vpp |-> $stable(r.addr))
    else $error("address moved at high supply");
  data_stable_a: assert property (@(posedge clk) disable iff (!reset_n)
    r.drive |-> $stable(r.wdata))
    else $error("pattern moved while driven");
  drive_supply_a: assert property (@(posedge clk) disable iff (!reset_n)
    r.drive |-> r.vpp)
    else $error("data driven at normal supply");
  data_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    $fell(r.ce) && r.vpp |-> r.drive)
    else $error("data released before strobe fell");
  fail_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(r.vpp) |-> !r.fail)
    else $error("stale fail flag at program start");

  // Read, idle and answer
  read_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
    r.st == uvp_pkg::ST_RD_SETUP |-> !r.ce && r.oe && !r.vpp)
    else $error("gate fell before enable settled");
  idle_standby_a: assert property (@(posedge clk) disable iff (!reset_n)
    r.st == uvp_pkg::ST_IDLE |-> r.ce && r.oe && !r.drive)
    else $error("idle pins not in standby");
  valid_pulse_a: assert property (@(posedge clk) disable iff (!reset_n)
    r.valid |=> !r.valid)
    else $error("answer pulse longer than one cycle");
endmodule

// *** uvp_eprom_model.sv ***
`timescale 1ns/1ps
module uvp_eprom_model (
  input wire logic [10:0] memAddr, // Address pins
  input wire logic [7:0] hostData, // Pattern from the host
  input wire logic hostOe, // Host drives data pins
  input wire logic chipEnableProgramStrobe, // Enable low, pulse high
  input wire logic outputGateLow, // Output gate, active low
  input wire logic programSupplyHigh, // 1 = program supply
  output logic [7:0] pinData // Device side of data pins
);
  // ----------------------------------------
  // Static array, level decoded reads, programming on the strobe's rising edge
  // ----------------------------------------
  logic [7:0] mem [0:2047];
  logic [7:0] lastOut = 8'hff;
  logic drive;

  // Shipped erased: every bit reads one
  initial
    foreach (mem[i]) mem[i] = 8'hff;

  // Pulse only programs with high supply and gate high; zeros only
  always @(posedge chipEnableProgramStrobe)
    if (programSupplyHigh && outputGateLow && hostOe)
      mem[memAddr] = mem[memAddr] & hostData;

  // Enable and gate both low drive data, either supply
  assign drive = !chipEnableProgramStrobe && !outputGateLow;

  // Released pins show the inverse, so stale data never passes
  always @(drive or memAddr)
  begin
    if (drive)
    begin
      lastOut = mem[memAddr];
      pinData <= #100 lastOut;
    end
    else
      pinData <= #100 ~lastOut;
  end
endmodule

// *** uvp_host_bench.sv ***
`timescale 1ns/1ps
module uvp_host_bench;
  localparam int PULSE = 20;
  localparam int SETUP = 3;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic readReq = 1'b0;
  logic progReq = 1'b0;
  logic [10:0] reqAddr = 11'h000;
  logic [7:0] reqData = 8'h00;
  logic reqReady, rspValid, progFail, memDataOe;
  logic [7:0] rspData, memDataOut, pinData, memDataIn;
  logic [10:0] memAddr, addr;
  logic chipEnableProgramStrobe, outputGateLow, programSupplyHigh;
  logic prevSupply = 1'b0;
  logic prevGate = 1'b0;
  logic prevStrobe = 1'b0;
  logic [15:0] lfsrState = 16'h002a;
  logic [7:0] shadow [0:2047];
  int miscompares = 0;
  int num_checks = 0;
  int hiCount = 0;

  // ----------------------------------------
  // Clock, wiring, instances
  // ----------------------------------------
  always #10 clk = ~clk;
  assign memDataIn = memDataOe ? memDataOut : pinData;

  uvp_host #(.PULSE_CYCLES(PULSE), .SETUP_CYCLES(SETUP)) u_uvp_host (
    .clk(clk), .reset_n(reset_n), .readReq(readReq), .progReq(progReq),
    .reqAddr(reqAddr), .reqData(reqData), .reqReady(reqReady),
    .rspData(rspData), .rspValid(rspValid), .progFail(progFail),
    .memAddr(memAddr), .memDataIn(memDataIn), .memDataOut(memDataOut),
    .memDataOe(memDataOe), .chipEnableProgramStrobe(chipEnableProgramStrobe),
    .outputGateLow(outputGateLow), .programSupplyHigh(programSupplyHigh));

  uvp_eprom_model u_uvp_eprom_model (
    .memAddr(memAddr), .hostData(memDataOut), .hostOe(memDataOe),
    .chipEnableProgramStrobe(chipEnableProgramStrobe),
    .outputGateLow(outputGateLow),
    .programSupplyHigh(programSupplyHigh), .pinData(pinData));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // A pulse can only clear bits of the stored word
  function automatic logic [7:0] programmed_word(input logic [7:0] old,
                                                 input logic [7:0] d);
    return old & d;
  endfunction

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // One request, held for the accepting edge, then wait for the answer
  task automatic run_op(input logic isProg, input logic [10:0] a,
                        input logic [7:0] d);
    int n;
    n = 0;
    while (reqReady !== 1'b1 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    #1;
    progReq = isProg;
    // Read request sometimes rides along to exercise program priority
    readReq = !isProg || lfsrState[15];
    reqAddr = a;
    reqData = d;
    @(posedge clk);
    #1;
    progReq = 1'b0;
    readReq = 1'b0;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (rspValid !== 1'b1 && n < 400);
    check({7'h00, rspValid}, 8'h01);
  endtask

  task automatic do_read(input logic [10:0] a);
    run_op(1'b0, a, 8'h00);
    check(rspData, shadow[a]);
  endtask

  // Fail is expected when a zero bit would have to turn back to one
  task automatic do_prog(input logic [10:0] a, input logic [7:0] d);
    logic expFail;
    expFail = (programmed_word(shadow[a], d) != d);
    shadow[a] = programmed_word(shadow[a], d);
    run_op(1'b1, a, d);
    check(rspData, shadow[a]);
    check({7'h00, progFail}, {7'h00, expFail});
  endtask

  // ----------------------------------------
  // Pin watchers: pulse length, gate, supply
  // ----------------------------------------
  always @(negedge clk)
  begin
    if (reset_n && programSupplyHigh && chipEnableProgramStrobe)
    begin
      hiCount++;
      check({7'h00, outputGateLow}, 8'h01);
    end
    else if (hiCount != 0)
    begin
      check(8'(hiCount), 8'(PULSE));
      hiCount = 0;
    end
    // Both sides of the switch count: before and after the edge
    if (programSupplyHigh !== prevSupply && ((outputGateLow
        && chipEnableProgramStrobe) || (prevGate && prevStrobe)))
      check(8'h01, 8'h00);
    if (reset_n && reqReady === 1'b1)
      check({4'h0, memDataOe, outputGateLow, chipEnableProgramStrobe,
             programSupplyHigh}, 8'h06);
    prevSupply = programSupplyHigh;
    prevGate = outputGateLow;
    prevStrobe = chipEnableProgramStrobe;
  end

  // Cut a hang short well beyond the expected run
  initial
  begin
    #500000;
    miscompares++;
    tally_and_finish();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    foreach (shadow[i]) shadow[i] = 8'hff;
    repeat (8) @(posedge clk);
    #1;
    reset_n = 1'b1;
    do_read(11'h000);
    do_read(11'h7ff);
    do_prog(11'h7ff, 8'h00);
    do_prog(11'h7ff, 8'hff);
    do_prog(11'h000, 8'h5a);
    for (int i = 0; i < 16; i++)
    begin
      lfsrState = lfsr_next(lfsrState);
      addr = lfsrState[10:0];
      lfsrState = lfsr_next(lfsrState);
      do_prog(addr, lfsrState[7:0]);
      do_read(addr);
    end
    tally_and_finish();
  end
endmodule
